// ### hdl/crs_pkg.sv
// Constants, operation codes and register map of the register, stack and PC core.
// Operation
// - B is a 4-bit temporary, upper transfer half.
// - E is 8 bits; B high, A low.
// - E is not reset by hardware.
// - D is 3 bits; D:A gives in-page address.
// - Upper flag set: fetch top bits into D.
// - Upper flag clear: table fetch leaves D alone.
// - Upper flag set, cleared by instructions; resets zero.
// - Eight return registers; push on call, interrupt, table.
// - Ninth push silently overwrites the oldest entry.
// - 3-bit depth pointer, copyable into A.
// - One-stage context saved only on interrupt entry.
// - Pending skip is saved with the context.
// - PC advances by length or loads target.
// - Page above bit 6; offset wraps to next page.
// - Pointer has group, file, digit; digit picks port bit.
// - Group register is not reset.
// - ROM words 10 bits, 128-word pages, 32 pages.
// - Interrupt loads source vector in page one.
// - Page-two call instruction reaches page two from anywhere; the via-regs call takes the page of op_addr.
// - Table fetch returns low eight ROM bits.
// - RAM 256x4 with bit set, clear, test.
// - Take interrupt when request, enable, global all set.
// - Accumulator is a 4-bit register.
// - Taking an interrupt clears global enable.
package crs_pkg;
    localparam int PC_W = 12;
    localparam int PAGE_W = 5;
    localparam int OFS_W = 7;
    localparam int ROM_W = 10;
    localparam int ROM_PAGES = 32;
    localparam int STK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int DATA_W = 4;
    localparam int E_W = 8;
    localparam int D_W = 3;
    localparam int RAM_AW = 8;
    localparam int IRQ_N = 5;
    localparam int OP_W = 5;
    localparam int LEN_W = 2;
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam int PORTD_MAX = 16;
    localparam logic [PAGE_W-1:0] PAGE_IRQ = 5'h01;
    localparam logic [PAGE_W-1:0] PAGE_CALL = 5'h02;
    localparam logic [IRQ_N-1:0][OFS_W-1:0] IRQ_OFS = {7'h0E, 7'h0C, 7'h06, 7'h04, 7'h00};
    localparam logic [OP_W-1:0] OP_NOP = 5'h00;
    localparam logic [OP_W-1:0] OP_LDA = 5'h01;
    localparam logic [OP_W-1:0] OP_LDB = 5'h02;
    localparam logic [OP_W-1:0] OP_TEAB = 5'h03;
    localparam logic [OP_W-1:0] OP_TABE = 5'h04;
    localparam logic [OP_W-1:0] OP_TDA = 5'h05;
    localparam logic [OP_W-1:0] OP_JMP = 5'h06;
    localparam logic [OP_W-1:0] OP_CALL = 5'h07;
    localparam logic [OP_W-1:0] OP_PAGE2_CALL_INSTR = 5'h08;
    localparam logic [OP_W-1:0] OP_PAGE_JUMP_VIA_REGS = 5'h09;
    localparam logic [OP_W-1:0] OP_PAGE2_CALL_VIA_REGS = 5'h0A;
    localparam logic [OP_W-1:0] OP_ROM_TABLE_FETCH = 5'h0B;
    localparam logic [OP_W-1:0] OP_RET = 5'h0C;
    localparam logic [OP_W-1:0] OP_RETURN_FROM_IRQ = 5'h0D;
    localparam logic [OP_W-1:0] OP_UPPER_FETCH_ON = 5'h0E;
    localparam logic [OP_W-1:0] OP_UPPER_FETCH_OFF = 5'h0F;
    localparam logic [OP_W-1:0] OP_DEPTH_TO_ACC = 5'h10;
    localparam logic [OP_W-1:0] OP_EI = 5'h11;
    localparam logic [OP_W-1:0] OP_DI = 5'h12;
    localparam logic [OP_W-1:0] OP_LDDP = 5'h13;
    localparam logic [OP_W-1:0] OP_RAM_BIT_SET = 5'h14;
    localparam logic [OP_W-1:0] OP_RAM_BIT_CLEAR = 5'h15;
    localparam logic [OP_W-1:0] OP_RAM_BIT_TEST_SKIP = 5'h16;
    localparam logic [OP_W-1:0] OP_PORT_LINE_SET = 5'h17;
    localparam logic [OP_W-1:0] OP_PORT_LINE_CLEAR = 5'h18;
    localparam logic [OP_W-1:0] OP_PORT_LINE_TEST_SKIP = 5'h19;
    localparam logic [OP_W-1:0] OP_SC = 5'h1A;
    localparam logic [OP_W-1:0] OP_RC = 5'h1B;
    localparam logic [OP_W-1:0] OP_TAM = 5'h1C;
    localparam logic [OP_W-1:0] OP_TMA = 5'h1D;
    localparam logic [OP_W-1:0] OP_SKIP_COND = 5'h1E;
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] REG_PC = 4'h1;
    localparam logic [REG_AW-1:0] REG_STAT = 4'h2;
    localparam logic [REG_AW-1:0] REG_AB = 4'h3;
    localparam logic [REG_AW-1:0] REG_E = 4'h4;
    localparam logic [REG_AW-1:0] REG_D = 4'h5;
    localparam logic [REG_AW-1:0] REG_DP = 4'h6;
    localparam logic [REG_AW-1:0] REG_PORTD = 4'h7;
    localparam int CTRL_IRQ_ENABLE_BIT = 0;
    localparam int CTRL_UPPER_FLAG_BIT = 1;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    typedef enum logic [3:0] {
        ST_EXEC = 4'h1,
        ST_TWAIT = 4'h2,
        ST_TDATA = 4'h4,
        ST_RAM = 4'h8
    } crs_state_e;
endpackage

// ### hdl/crs_ram.sv
// Data memory of 4-bit words with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module crs_ram
    import crs_pkg::*;
#(
    parameter int AW = RAM_AW,
    parameter int DW = DATA_W
)
(
    input wire logic clk,
    input wire logic [AW-1:0] addr,
    input wire logic we,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_q [2**AW];

    if (AW < 1 || DW < 1)
    begin : g_chk
        $error("crs_ram needs positive widths");
    end

    always_ff @(posedge clk)
    begin
        if (we)
            mem_q[addr] <= wdata;
    end

    always_ff @(posedge clk)
    begin
        rdata <= mem_q[addr];
    end
endmodule
`default_nettype wire

// ### hdl/crs_core.sv
// Program sequencing core: working registers, return stack, PC, RAM pointer, context save.
`timescale 1ns/100ps
`default_nettype none
module crs_core
    import crs_pkg::*;
#(
    parameter int PORTD_W = 8
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [OP_W-1:0] op_code,
    input wire logic [LEN_W-1:0] op_len,
    input wire logic [PC_W-1:0] op_addr,
    input wire logic [DATA_W-1:0] op_arg,
    output logic [PC_W-1:0] rom_addr,
    input wire logic [ROM_W-1:0] rom_word,
    input wire logic [IRQ_N-1:0] irq_req,
    input wire logic [IRQ_N-1:0] irq_en,
    output logic [IRQ_N-1:0] irq_ack,
    output logic [DATA_W-1:0] acc,
    output logic skip_flag,
    output logic [PORTD_W-1:0] port_d,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_DW-1:0] reg_rdata
);
    crs_state_e st_q;
    logic [PC_W-1:0] pc_q;
    logic [SP_W-1:0] sp_q;
    logic [PC_W-1:0] stk_q [STK_DEPTH];
    logic [DATA_W-1:0] a_q;
    logic [DATA_W-1:0] b_q;
    logic [E_W-1:0] e_q;
    logic [D_W-1:0] d_q;
    logic table_upper_bits_flag_q;
    logic skip_q;
    logic carry_bit_q;
    logic global_irq_enable_q;
    logic ei_arm_q;
    logic z_q;
    logic [3:0] x_q;
    logic [3:0] y_q;
    logic [PORTD_W-1:0] pd_q;
    logic [OP_W-1:0] ram_op_q;
    logic [1:0] ram_bit_q;
    logic ctx_z_q;
    logic [3:0] ctx_x_q;
    logic [3:0] ctx_y_q;
    logic ctx_carry_bit_q;
    logic ctx_skip_q;
    logic [DATA_W-1:0] ctx_a_q;
    logic [DATA_W-1:0] ctx_b_q;
    logic accept;
    logic irq_take;
    logic exec;
    logic skipping;
    logic push_en;
    logic pop_en;
    logic [IRQ_N-1:0] irq_hit;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] ind_target;
    logic [PC_W-1:0] pop_pc;
    logic [PC_W-1:0] vec_pc;
    logic [PORTD_MAX-1:0] pd_ext;
    logic [PORTD_MAX-1:0] y_mask;
    logic [DATA_W-1:0] ram_rdata;
    logic [DATA_W-1:0] ram_wdata;
    logic [DATA_W-1:0] bit_mask;
    logic ram_we;

    if (PORTD_W < 1 || PORTD_W > PORTD_MAX || STK_DEPTH != 2**SP_W || PC_W != PAGE_W + OFS_W
        || ROM_PAGES != 2**PAGE_W)
    begin : g_chk
        $error("crs_core parameters out of range");
    end

    // An interrupt replaces the offered instruction; the decoder refetches from the vector.
    assign irq_hit = irq_req & irq_en & {IRQ_N{global_irq_enable_q}};
    assign accept = op_valid && (st_q == ST_EXEC);
    assign irq_take = accept && (|irq_hit);
    assign exec = accept && !irq_take && !skip_q;
    assign skipping = accept && !irq_take && skip_q;
    assign op_ready = (st_q == ST_EXEC);
    assign irq_ack = irq_take ? (irq_hit & IRQ_N'(~irq_hit + 1'b1)) : '0;
    assign pc_inc = pc_q + PC_W'(op_len);
    assign ind_target = {op_addr[PC_W-1:OFS_W], d_q, a_q};
    assign pop_pc = stk_q[sp_q - 1'b1];
    assign push_en = irq_take || (exec && (op_code == OP_CALL || op_code == OP_PAGE2_CALL_INSTR
        || op_code == OP_PAGE2_CALL_VIA_REGS || op_code == OP_ROM_TABLE_FETCH));
    assign pop_en = (st_q == ST_TDATA)
        || (exec && (op_code == OP_RET || op_code == OP_RETURN_FROM_IRQ));
    assign pd_ext = PORTD_MAX'(pd_q);
    assign y_mask = PORTD_MAX'(1) << y_q;
    assign bit_mask = DATA_W'(1) << ram_bit_q;
    assign rom_addr = pc_q;
    assign acc = a_q;
    assign skip_flag = skip_q;
    assign port_d = pd_q;

    // Lowest source number wins when several are pending.
    always_comb
    begin
        vec_pc = {PAGE_IRQ, IRQ_OFS[0]};
        for (int i = IRQ_N - 1; i >= 0; i--)
        begin
            if (irq_hit[i])
                vec_pc = {PAGE_IRQ, IRQ_OFS[i]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st_q <= ST_EXEC;
        else
        begin
            unique case (st_q)
                ST_EXEC:
                    if (exec && op_code == OP_ROM_TABLE_FETCH)
                        st_q <= ST_TWAIT;
                    else if (exec && (op_code == OP_RAM_BIT_SET || op_code == OP_RAM_BIT_CLEAR
                        || op_code == OP_RAM_BIT_TEST_SKIP || op_code == OP_TAM))
                        st_q <= ST_RAM;
                ST_TWAIT:
                    st_q <= ST_TDATA;
                ST_TDATA:
                    st_q <= ST_EXEC;
                ST_RAM:
                    st_q <= ST_EXEC;
                default:
                    st_q <= ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pc_q <= PC_RESET;
        else if (irq_take)
            pc_q <= vec_pc;
        else if (st_q == ST_TDATA)
            pc_q <= pop_pc;
        else if (skipping)
            pc_q <= pc_inc;
        else if (exec)
        begin
            case (op_code)
                OP_JMP, OP_CALL: pc_q <= op_addr;
                OP_PAGE2_CALL_INSTR: pc_q <= {PAGE_CALL, op_addr[OFS_W-1:0]};
                OP_PAGE_JUMP_VIA_REGS, OP_PAGE2_CALL_VIA_REGS: pc_q <= ind_target;
                OP_ROM_TABLE_FETCH: pc_q <= ind_target;
                OP_RET, OP_RETURN_FROM_IRQ: pc_q <= pop_pc;
                default: pc_q <= pc_inc;
            endcase
        end
    end

    // Depth wraps modulo eight, so a ninth push overwrites the oldest entry unflagged.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            sp_q <= '0;
        else if (push_en)
            sp_q <= sp_q + 1'b1;
        else if (pop_en)
            sp_q <= sp_q - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (push_en)
            stk_q[sp_q] <= irq_take ? pc_q : pc_inc;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            a_q <= '0;
            b_q <= '0;
        end
        else if (st_q == ST_TDATA)
            {b_q, a_q} <= rom_word[E_W-1:0];
        else if (st_q == ST_RAM && ram_op_q == OP_TAM)
            a_q <= ram_rdata;
        else if (exec)
        begin
            case (op_code)
                OP_LDA: a_q <= op_arg;
                OP_LDB: b_q <= op_arg;
                OP_TABE: {b_q, a_q} <= e_q;
                OP_DEPTH_TO_ACC: a_q <= DATA_W'(sp_q);
                OP_RETURN_FROM_IRQ:
                begin
                    a_q <= ctx_a_q;
                    b_q <= ctx_b_q;
                end
                default: a_q <= a_q;
            endcase
        end
    end

    // E and D are data holders left uninitialised by reset.
    always_ff @(posedge clk)
    begin
        if (exec && op_code == OP_TEAB)
            e_q <= {b_q, a_q};
    end

    always_ff @(posedge clk)
    begin
        if (st_q == ST_TDATA && table_upper_bits_flag_q)
            d_q <= {1'b0, rom_word[ROM_W-1:ROM_W-2]};
        else if (exec && op_code == OP_TDA)
            d_q <= op_arg[D_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            table_upper_bits_flag_q <= 1'b0;
        else if (exec && op_code == OP_UPPER_FETCH_ON)
            table_upper_bits_flag_q <= 1'b1;
        else if (exec && op_code == OP_UPPER_FETCH_OFF)
            table_upper_bits_flag_q <= 1'b0;
        else if (reg_wr && reg_addr == REG_CTRL)
            table_upper_bits_flag_q <= reg_wdata[CTRL_UPPER_FLAG_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            skip_q <= 1'b0;
        else if (irq_take || skipping)
            skip_q <= 1'b0;
        else if (st_q == ST_RAM && ram_op_q == OP_RAM_BIT_TEST_SKIP)
            skip_q <= ((ram_rdata & bit_mask) == '0);
        else if (exec && op_code == OP_PORT_LINE_TEST_SKIP)
            skip_q <= ((pd_ext & y_mask) == '0);
        else if (exec && op_code == OP_SKIP_COND)
            skip_q <= op_arg[0];
        else if (exec && op_code == OP_RETURN_FROM_IRQ)
            skip_q <= ctx_skip_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            carry_bit_q <= 1'b0;
        else if (exec && op_code == OP_SC)
            carry_bit_q <= 1'b1;
        else if (exec && op_code == OP_RC)
            carry_bit_q <= 1'b0;
        else if (exec && op_code == OP_RETURN_FROM_IRQ)
            carry_bit_q <= ctx_carry_bit_q;
    end

    // Enable takes effect only after the instruction that follows it.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            global_irq_enable_q <= 1'b0;
            ei_arm_q <= 1'b0;
        end
        else if (irq_take)
        begin
            global_irq_enable_q <= 1'b0;
            ei_arm_q <= 1'b0;
        end
        else if (exec && op_code == OP_DI)
        begin
            global_irq_enable_q <= 1'b0;
            ei_arm_q <= 1'b0;
        end
        else if (exec && op_code == OP_EI)
            ei_arm_q <= 1'b1;
        else if (accept && ei_arm_q)
        begin
            global_irq_enable_q <= 1'b1;
            ei_arm_q <= 1'b0;
        end
        else if (reg_wr && reg_addr == REG_CTRL)
            global_irq_enable_q <= reg_wdata[CTRL_IRQ_ENABLE_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            x_q <= '0;
            y_q <= '0;
        end
        else if (exec && op_code == OP_LDDP)
        begin
            x_q <= op_addr[7:4];
            y_q <= op_addr[3:0];
        end
        else if (exec && op_code == OP_RETURN_FROM_IRQ)
        begin
            x_q <= ctx_x_q;
            y_q <= ctx_y_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (exec && op_code == OP_LDDP)
            z_q <= op_addr[8];
        else if (exec && op_code == OP_RETURN_FROM_IRQ)
            z_q <= ctx_z_q;
    end

    always_ff @(posedge clk)
    begin
        if (irq_take)
        begin
            ctx_z_q <= z_q;
            ctx_x_q <= x_q;
            ctx_y_q <= y_q;
            ctx_carry_bit_q <= carry_bit_q;
            ctx_skip_q <= skip_q;
            ctx_a_q <= a_q;
            ctx_b_q <= b_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pd_q <= '0;
        else if (exec && op_code == OP_PORT_LINE_SET)
            pd_q <= pd_q | PORTD_W'(y_mask);
        else if (exec && op_code == OP_PORT_LINE_CLEAR)
            pd_q <= pd_q & ~PORTD_W'(y_mask);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ram_op_q <= OP_NOP;
            ram_bit_q <= '0;
        end
        else if (exec)
        begin
            ram_op_q <= op_code;
            ram_bit_q <= op_arg[1:0];
        end
    end

    always_comb
    begin
        ram_we = 1'b0;
        ram_wdata = a_q;
        if (exec && op_code == OP_TMA)
            ram_we = 1'b1;
        else if (st_q == ST_RAM && ram_op_q == OP_RAM_BIT_SET)
        begin
            ram_we = 1'b1;
            ram_wdata = ram_rdata | bit_mask;
        end
        else if (st_q == ST_RAM && ram_op_q == OP_RAM_BIT_CLEAR)
        begin
            ram_we = 1'b1;
            ram_wdata = ram_rdata & ~bit_mask;
        end
    end

    crs_ram #(
        .AW(RAM_AW),
        .DW(DATA_W)
    ) u_ram (
        .clk(clk),
        .addr({x_q, y_q}),
        .we(ram_we),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_b || !reg_rd)
            reg_rdata <= '0;
        else
        begin
            case (reg_addr)
                REG_CTRL: reg_rdata <= REG_DW'({table_upper_bits_flag_q, global_irq_enable_q});
                REG_PC: reg_rdata <= REG_DW'(pc_q);
                REG_STAT: reg_rdata <= REG_DW'({ei_arm_q, carry_bit_q, skip_q, sp_q});
                REG_AB: reg_rdata <= REG_DW'({b_q, a_q});
                REG_E: reg_rdata <= REG_DW'(e_q);
                REG_D: reg_rdata <= REG_DW'(d_q);
                REG_DP: reg_rdata <= REG_DW'({z_q, x_q, y_q});
                REG_PORTD: reg_rdata <= REG_DW'(pd_q);
                default: reg_rdata <= '0;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_table_seq;
        exec && op_code == OP_ROM_TABLE_FETCH |=> st_q == ST_TWAIT && sp_q == $past(sp_q) + 1'b1
            ##1 st_q == ST_TDATA ##1 st_q == ST_EXEC && sp_q == $past(sp_q, 3);
    endproperty
    a_table_seq: assert property (p_table_seq) else $error("table fetch stack sequence wrong");

    property p_table_d_load;
        st_q == ST_TDATA && table_upper_bits_flag_q
            |=> d_q == {1'b0, $past(rom_word[ROM_W-1:ROM_W-2])};
    endproperty
    a_table_d_load: assert property (p_table_d_load) else $error("D not loaded from fetch");

    property p_table_d_keep;
        st_q == ST_TDATA && !table_upper_bits_flag_q |=> $stable(d_q);
    endproperty
    a_table_d_keep: assert property (p_table_d_keep) else $error("D changed by fetch");

    property p_irq_entry;
        irq_take |=> pc_q[PC_W-1:OFS_W] == PAGE_IRQ && !global_irq_enable_q
            && stk_q[$past(sp_q)] == $past(pc_q);
    endproperty
    a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong");

    property p_irq_gate;
        irq_take |-> global_irq_enable_q && (irq_req & irq_en & irq_ack) == irq_ack
            && $onehot(irq_ack);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt taken without all enables");

    property p_ctx_roundtrip;
        exec && op_code == OP_RETURN_FROM_IRQ |=> a_q == ctx_a_q && b_q == ctx_b_q
            && skip_q == ctx_skip_q && carry_bit_q == ctx_carry_bit_q;
    endproperty
    a_ctx_roundtrip: assert property (p_ctx_roundtrip) else $error("context not restored");

    property p_ctx_save;
        irq_take |=> ctx_a_q == $past(a_q) && ctx_b_q == $past(b_q)
            && ctx_skip_q == $past(skip_q) && ctx_carry_bit_q == $past(carry_bit_q);
    endproperty
    a_ctx_save: assert property (p_ctx_save) else $error("context not saved");

    property p_pc_step;
        exec && op_code == OP_NOP |=> pc_q == $past(pc_q) + PC_W'($past(op_len));
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("PC did not advance");

    property p_depth_read;
        exec && op_code == OP_DEPTH_TO_ACC |=> a_q == DATA_W'($past(sp_q));
    endproperty
    a_depth_read: assert property (p_depth_read) else $error("depth not copied to A");

    property p_page2_call;
        exec && op_code == OP_PAGE2_CALL_INSTR |=> pc_q[PC_W-1:OFS_W] == PAGE_CALL;
    endproperty
    a_page2_call: assert property (p_page2_call) else $error("page two call missed");
endmodule
`default_nettype wire

// ### bench/crs_rom_model.sv
// Synchronous program memory model answering the core's fetch address.
`timescale 1ns/100ps
`default_nettype none
module crs_rom_model
    import crs_pkg::*;
(
    input wire logic clk,
    input wire logic [PC_W-1:0] addr,
    output logic [ROM_W-1:0] word
);
    // Each word is a fixed scramble of the low ten address bits, so words repeat every 1024 addresses.
    always_ff @(posedge clk)
    begin
        word <= addr[ROM_W-1:0] ^ 10'h35A;
    end
endmodule
`default_nettype wire

// ### bench/test_crs_core.sv
// Self-checking bench for the register, stack and PC core.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_crs_core
    import crs_pkg::*;
;
    localparam logic [ROM_W-1:0] TW = 10'h1D3 ^ 10'h35A;
    logic clk, rst_b, op_valid, op_ready, skip_flag, reg_wr, reg_rd;
    logic [OP_W-1:0] op_code;
    logic [LEN_W-1:0] op_len;
    logic [PC_W-1:0] op_addr, rom_addr, pc;
    logic [DATA_W-1:0] op_arg, acc;
    logic [ROM_W-1:0] rom_word;
    logic [IRQ_N-1:0] irq_req, irq_en, irq_ack, ack;
    logic [7:0] port_d;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata, reg_rdata;
    int n_mismatch, n_tests, cyc;

    crs_core uut (.clk, .rst_b, .op_valid, .op_ready, .op_code, .op_len, .op_addr, .op_arg,
        .rom_addr, .rom_word, .irq_req, .irq_en, .irq_ack, .acc, .skip_flag, .port_d,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    crs_rom_model rom (.clk, .addr(rom_addr), .word(rom_word));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task give_verdict;
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK(reg_rdata, e)
    endtask

    // Holds the instruction until an edge where the core is ready takes it.
    task op(input logic [OP_W-1:0] c, input logic [PC_W-1:0] a = 12'h000,
            input logic [DATA_W-1:0] g = 4'h0, input logic [LEN_W-1:0] l = 2'd1);
        int k;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_addr <= a;
        op_arg <= g;
        op_len <= l;
        k = 0;
        @(negedge clk);
        while (op_ready !== 1'b1 && k < 20)
        begin
            k++;
            @(negedge clk);
        end
        if (k == 20)
            n_mismatch++;
        ack = irq_ack;
        @(posedge clk);
        op_valid <= 1'b0;
        pc = pc + 12'(l);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict;
        end
    end

    initial
    begin
        rst_b = 1'b0;
        op_valid = 1'b0;
        op_code = OP_NOP;
        op_len = 2'd1;
        op_addr = 12'h000;
        op_arg = 4'h0;
        irq_req = 5'h00;
        irq_en = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        pc = 12'h000;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(REG_CTRL, 16'h0000);
        rd(REG_STAT, 16'h0000);
        rd(REG_AB, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(REG_CTRL, 16'h0002);
        rd(REG_CTRL, 16'h0002);
        wr(REG_CTRL, 16'h0000);
        op(OP_LDA, 12'h000, 4'h5);
        op(OP_LDB, 12'h000, 4'hA);
        op(OP_TEAB);
        rd(REG_AB, 16'h00A5);
        rd(REG_E, 16'h00A5);
        op(OP_LDA, 12'h000, 4'h0);
        op(OP_LDB, 12'h000, 4'h0);
        op(OP_TABE);
        rd(REG_AB, 16'h00A5);
        op(OP_TDA, 12'h000, 4'h5);
        op(OP_LDA, 12'h000, 4'h3);
        rd(REG_D, 16'h0005);
        op(OP_ROM_TABLE_FETCH, 12'h180);
        op(OP_NOP);
        rd(REG_AB, {8'h00, TW[7:0]});
        rd(REG_D, 16'h0005);
        rd(REG_PC, {4'h0, pc});
        op(OP_UPPER_FETCH_ON);
        rd(REG_CTRL, 16'h0002);
        op(OP_LDA, 12'h000, 4'h3);
        op(OP_ROM_TABLE_FETCH, 12'h180);
        op(OP_NOP);
        rd(REG_D, {14'h0000, TW[9:8]});
        op(OP_UPPER_FETCH_OFF);
        rd(REG_CTRL, 16'h0000);
        op(OP_JMP, 12'h07E);
        op(OP_NOP, 12'h000, 4'h0, 2'd2);
        rd(REG_PC, 16'h0080);
        op(OP_CALL, 12'h200);
        op(OP_PAGE2_CALL_INSTR, 12'h010);
        rd(REG_PC, 16'h0110);
        op(OP_CALL, 12'h300);
        op(OP_DEPTH_TO_ACC);
        op(OP_NOP);
        rd(REG_STAT, 16'h0003);
        rd(REG_AB, {8'h00, TW[7:4], 4'h3});
        op(OP_RET);
        rd(REG_PC, 16'h0111);
        // Seven more pushes wrap the depth and overwrite the oldest entry.
        for (int i = 0; i < 7; i++)
            op(OP_CALL, 12'h400);
        rd(REG_STAT, 16'h0001);
        op(OP_RET);
        rd(REG_PC, 16'h0401);
        op(OP_LDA, 12'h000, 4'h6);
        op(OP_LDB, 12'h000, 4'h9);
        op(OP_SC);
        op(OP_EI);
        op(OP_SKIP_COND, 12'h000, 4'h1);
        irq_req <= 5'b01100;
        irq_en <= 5'b01000;
        op(OP_LDA, 12'h000, 4'hF);
        `CHK(ack, 5'b01000);
        rd(REG_PC, 16'h008C);
        rd(REG_CTRL, 16'h0000);
        op(OP_LDA, 12'h000, 4'h0);
        op(OP_RC);
        op(OP_RETURN_FROM_IRQ);
        rd(REG_STAT, 16'h0018);
        `CHK(skip_flag, 1'b1)
        rd(REG_AB, 16'h0096);
        `CHK(acc, 4'h6)
        op(OP_LDA, 12'h000, 4'hF);
        rd(REG_AB, 16'h0096);
        rd(REG_PC, 16'h0407);
        irq_req <= 5'h00;
        op(OP_LDDP, 12'h1A3);
        rd(REG_DP, 16'h01A3);
        op(OP_LDA, 12'h000, 4'h0);
        op(OP_TMA);
        op(OP_RAM_BIT_SET, 12'h000, 4'h2);
        op(OP_RAM_BIT_TEST_SKIP, 12'h000, 4'h0);
        op(OP_LDA, 12'h000, 4'hF);
        op(OP_TAM);
        op(OP_NOP);
        rd(REG_AB, 16'h0094);
        op(OP_RAM_BIT_CLEAR, 12'h000, 4'h2);
        op(OP_TAM);
        op(OP_NOP);
        rd(REG_AB, 16'h0090);
        op(OP_LDDP, 12'h003);
        op(OP_PORT_LINE_SET);
        op(OP_NOP);
        `CHK(port_d, 8'h08);
        op(OP_PORT_LINE_TEST_SKIP);
        rd(REG_STAT, 16'h0010);
        op(OP_PORT_LINE_CLEAR);
        op(OP_NOP);
        rd(REG_PORTD, 16'h0000);
        op(OP_PORT_LINE_TEST_SKIP);
        rd(REG_STAT, 16'h0018);
        op(OP_NOP);
        op(OP_PAGE2_CALL_VIA_REGS, 12'h100);
        rd(REG_PC, 16'h0120);
        op(OP_PAGE_JUMP_VIA_REGS, 12'h280);
        rd(REG_PC, 16'h02A0);
        op(OP_EI);
        op(OP_DI);
        op(OP_NOP);
        rd(REG_CTRL, 16'h0000);
        give_verdict;
    end
endmodule
`default_nettype wire
